// File: core/ecd_counter.sv
// Eight-bit down counter with modulo-N, single pass and edge demodulation modes.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module ecd_counter (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic stopRecovery,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Pins.
  input wire logic port3Pin1,
  input wire logic port2Pin0,
  input wire logic portOutData,
  output logic port3Pin4,
  // Interrupt.
  output logic irqOut
);
  // ***************************************************
  // Reset and input synchronisers.
  // ***************************************************
  logic [1:0] rstSync_r;
  logic [1:0] pinSyncA_r;
  logic [1:0] pinSyncB_r;
  logic edgePrev_r;
  logic rstLocal_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstLocal_b = rstSync_r[1];

  always_ff @(posedge sys_clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      pinSyncA_r <= 2'h0;
      pinSyncB_r <= 2'h0;
    end else begin
      pinSyncA_r <= {pinSyncA_r[0], port3Pin1};
      pinSyncB_r <= {pinSyncB_r[0], port2Pin0};
    end
  end

  // ***************************************************
  // Registers and state.
  // ***************************************************
  ecd_pkg::ecd_ctrl_t ctrl_r, ctrl_nxt;
  ecd_pkg::ecd_edge_t edge_r, edge_nxt;
  ecd_pkg::ecd_state_t state_r, state_nxt;
  logic [7:0] lowHold_r, lowHold_nxt;
  logic [7:0] highHold_r, highHold_nxt;
  logic [7:0] lowCapture_r, lowCapture_nxt;
  logic [7:0] highCapture_r, highCapture_nxt;
  logic [7:0] count_r, count_nxt;
  logic [2:0] divCnt_r, divCnt_nxt;
  logic [2:0] irqStatus_r, irqStatus_nxt;
  logic [2:0] irqMask_r, irqMask_nxt;
  logic pendRun_r, pendRun_nxt;
  logic pendSingle_r, pendSingle_nxt;
  logic pendValid_r, pendValid_nxt;
  logic pendClear_r, pendClear_nxt;
  logic timerOut_r, timerOut_nxt;
  logic [7:0] regRdData_nxt;
  logic port3Pin4_nxt;
  logic irqOut_nxt;
  logic edgeIn;
  logic riseQual;
  logic fallQual;
  logic tick;
  logic toEvent;
  logic ctrlWrite;
  logic [2:0] divMask;
  logic capRise;
  logic capFall;
  ecd_pkg::ecd_ctrl_t wrCtrl;
  ecd_pkg::ecd_edge_t wrEdge;

  assign edgeIn = edge_r.sourceSelect ? pinSyncB_r[1] : pinSyncA_r[1];
  assign riseQual = edgeIn && !edgePrev_r && edge_r.edgeSelect[0];
  assign fallQual = !edgeIn && edgePrev_r && edge_r.edgeSelect[1];
  assign divMask = (3'h1 << ctrl_r.prescaleSelect) - 3'h1;
  assign tick = ((divCnt_r & divMask) == divMask);
  assign toEvent = (state_r == ecd_pkg::ST_RUN) && tick && (count_r <= ecd_pkg::COUNT_ONE)
                   && !(edge_r.demodMode && (riseQual || fallQual));
  assign ctrlWrite = regWr && (regAddr == ecd_pkg::REG_CTRL);
  assign capRise = (state_r == ecd_pkg::ST_RUN) && edge_r.demodMode && riseQual;
  assign capFall = (state_r == ecd_pkg::ST_RUN) && edge_r.demodMode && fallQual && !riseQual;
  assign wrCtrl = regWrData;
  assign wrEdge = regWrData;

  // ***************************************************
  // Next-state logic.
  // ***************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    edge_nxt = edge_r;
    state_nxt = state_r;
    lowHold_nxt = lowHold_r;
    highHold_nxt = highHold_r;
    lowCapture_nxt = lowCapture_r;
    highCapture_nxt = highCapture_r;
    count_nxt = count_r;
    divCnt_nxt = divCnt_r + 3'h1;
    irqStatus_nxt = irqStatus_r;
    irqMask_nxt = irqMask_r;
    pendRun_nxt = pendRun_r;
    pendSingle_nxt = pendSingle_r;
    pendValid_nxt = pendValid_r;
    pendClear_nxt = pendClear_r;
    timerOut_nxt = timerOut_r;
    regRdData_nxt = 8'h00;
    // Staged commands take effect on the next counter clock tick.
    if (tick && pendValid_r) begin
      ctrl_nxt.enable = pendRun_r;
      ctrl_nxt.singlePass = pendSingle_r;
      pendValid_nxt = 1'b0;
      if (!pendRun_r) begin
        state_nxt = ecd_pkg::ST_IDLE;
      end else if (!ctrl_r.enable) begin
        timerOut_nxt = 1'b0;
        count_nxt = edge_r.demodMode ? ecd_pkg::COUNT_ALL_ONES : lowHold_r;
        state_nxt = edge_r.demodMode ? ecd_pkg::ST_WAIT_EDGE : ecd_pkg::ST_RUN;
      end
    end
    if (tick && pendClear_r) begin
      ctrl_nxt.timeOut = 1'b0;
      pendClear_nxt = 1'b0;
    end
    // Counting, capture and time-out.
    if (state_r == ecd_pkg::ST_WAIT_EDGE && (riseQual || fallQual) && !(tick && pendValid_r)) begin
      state_nxt = ecd_pkg::ST_RUN;
    end else if (state_r == ecd_pkg::ST_RUN && edge_r.demodMode && (riseQual || fallQual)) begin
      if (riseQual) begin
        lowCapture_nxt = ~count_r;
        edge_nxt.riseDetect = 1'b1;
        irqStatus_nxt[ecd_pkg::IRQ_RISE_BIT] = 1'b1;
      end else begin
        highCapture_nxt = ~count_r;
        edge_nxt.fallDetect = 1'b1;
        irqStatus_nxt[ecd_pkg::IRQ_FALL_BIT] = 1'b1;
      end
      count_nxt = ecd_pkg::COUNT_ALL_ONES;
    end else if (toEvent) begin
      if (edge_r.demodMode) begin
        count_nxt = ecd_pkg::COUNT_ALL_ONES;
      end else begin
        timerOut_nxt = !timerOut_r;
        count_nxt = timerOut_r ? lowHold_r : highHold_r;
        if (ctrl_r.singlePass) begin
          ctrl_nxt.enable = 1'b0;
          state_nxt = ecd_pkg::ST_IDLE;
        end
      end
    end else if (state_r == ecd_pkg::ST_RUN && tick) begin
      count_nxt = count_r - 8'h01;
    end
    // Register writes; a hardware set wins over a write-one clear.
    if (regWr) begin
      unique case (regAddr)
        ecd_pkg::REG_CTRL: begin
          pendRun_nxt = wrCtrl.enable;
          pendSingle_nxt = wrCtrl.singlePass;
          pendValid_nxt = 1'b1;
          if (wrCtrl.timeOut) begin
            pendClear_nxt = 1'b1;
          end
          ctrl_nxt.prescaleSelect = wrCtrl.prescaleSelect;
          ctrl_nxt.captureIntEn = wrCtrl.captureIntEn;
          ctrl_nxt.timeoutIntEn = wrCtrl.timeoutIntEn;
          ctrl_nxt.outputPinSelect = wrCtrl.outputPinSelect;
        end
        ecd_pkg::REG_LOW_HOLD: lowHold_nxt = regWrData;
        ecd_pkg::REG_HIGH_HOLD: highHold_nxt = regWrData;
        ecd_pkg::REG_EDGE_CTRL: begin
          edge_nxt.demodMode = wrEdge.demodMode;
          edge_nxt.sourceSelect = wrEdge.sourceSelect;
          edge_nxt.edgeSelect = wrEdge.edgeSelect;
          if (wrEdge.fallDetect && !capFall) begin
            edge_nxt.fallDetect = 1'b0;
          end
          if (wrEdge.riseDetect && !capRise) begin
            edge_nxt.riseDetect = 1'b0;
          end
        end
        ecd_pkg::REG_IRQ_STATUS: irqStatus_nxt = irqStatus_nxt & ~(regWrData[2:0] & ~{capFall, capRise, 1'b0});
        ecd_pkg::REG_IRQ_MASK: irqMask_nxt = regWrData[2:0];
        default: ;
      endcase
    end
    if (toEvent) begin
      ctrl_nxt.timeOut = 1'b1;
      irqStatus_nxt[ecd_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
    end
    // Stop-mode recovery clears enable, singlePass and outputPinSelect and keeps the power-on-only bits.
    if (stopRecovery) begin
      ctrl_nxt.enable = 1'b0;
      ctrl_nxt.singlePass = 1'b0;
      ctrl_nxt.outputPinSelect = 1'b0;
      pendValid_nxt = 1'b0;
      state_nxt = ecd_pkg::ST_IDLE;
    end
    if (regRd) begin
      unique case (regAddr)
        ecd_pkg::REG_CTRL: regRdData_nxt = ctrl_r;
        ecd_pkg::REG_LOW_HOLD: regRdData_nxt = lowHold_r;
        ecd_pkg::REG_HIGH_HOLD: regRdData_nxt = highHold_r;
        ecd_pkg::REG_LOW_CAPTURE: regRdData_nxt = lowCapture_r;
        ecd_pkg::REG_HIGH_CAPTURE: regRdData_nxt = highCapture_r;
        ecd_pkg::REG_EDGE_CTRL: regRdData_nxt = edge_r;
        ecd_pkg::REG_IRQ_STATUS: regRdData_nxt = {5'h00, irqStatus_r};
        ecd_pkg::REG_IRQ_MASK: regRdData_nxt = {5'h00, irqMask_r};
        default: regRdData_nxt = 8'h00;
      endcase
    end
  end

  assign port3Pin4_nxt = ctrl_nxt.outputPinSelect ? timerOut_nxt : portOutData;
  assign irqOut_nxt = |(irqStatus_nxt & irqMask_nxt & {ctrl_nxt.captureIntEn, ctrl_nxt.captureIntEn,
                                                      ctrl_nxt.timeoutIntEn});

  // ***************************************************
  // State registers.
  // ***************************************************
  always_ff @(posedge sys_clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      ctrl_r <= ecd_pkg::CTRL_RESET;
      edge_r <= ecd_pkg::EDGE_RESET;
      state_r <= ecd_pkg::ST_IDLE;
      lowHold_r <= ecd_pkg::HOLD_RESET;
      highHold_r <= ecd_pkg::HOLD_RESET;
      lowCapture_r <= ecd_pkg::HOLD_RESET;
      highCapture_r <= ecd_pkg::HOLD_RESET;
      count_r <= ecd_pkg::HOLD_RESET;
      divCnt_r <= 3'h0;
      irqStatus_r <= ecd_pkg::IRQ_RESET;
      irqMask_r <= ecd_pkg::IRQ_RESET;
      pendRun_r <= 1'b0;
      pendSingle_r <= 1'b0;
      pendValid_r <= 1'b0;
      pendClear_r <= 1'b0;
      timerOut_r <= 1'b0;
      edgePrev_r <= 1'b0;
      regRdData <= 8'h00;
      port3Pin4 <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      edge_r <= edge_nxt;
      state_r <= state_nxt;
      lowHold_r <= lowHold_nxt;
      highHold_r <= highHold_nxt;
      lowCapture_r <= lowCapture_nxt;
      highCapture_r <= highCapture_nxt;
      count_r <= count_nxt;
      divCnt_r <= divCnt_nxt;
      irqStatus_r <= irqStatus_nxt;
      irqMask_r <= irqMask_nxt;
      pendRun_r <= pendRun_nxt;
      pendSingle_r <= pendSingle_nxt;
      pendValid_r <= pendValid_nxt;
      pendClear_r <= pendClear_nxt;
      timerOut_r <= timerOut_nxt;
      edgePrev_r <= edgeIn;
      regRdData <= regRdData_nxt;
      port3Pin4 <= port3Pin4_nxt;
      irqOut <= irqOut_nxt;
    end
  end

  // ***************************************************
  // Assertions.
  // ***************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstLocal_b);

  sequence seqRiseCapture;
    (state_r == ecd_pkg::ST_RUN) && edge_r.demodMode && riseQual && !stopRecovery;
  endsequence

  sequence seqFallCapture;
    (state_r == ecd_pkg::ST_RUN) && edge_r.demodMode && fallQual && !riseQual && !stopRecovery;
  endsequence

  a_enable_staged: assert property (ctrlWrite && !wrCtrl.enable && ctrl_r.enable && !tick && !toEvent
                                    && !stopRecovery |=> ctrl_r.enable)
    else $error("Stop acted before the next counter tick.");
  a_single_pass_stop: assert property (toEvent && !edge_r.demodMode && ctrl_r.singlePass
                                       |=> !ctrl_r.enable)
    else $error("Single pass did not stop at zero.");
  a_timeout_set: assert property (toEvent |=> ctrl_r.timeOut && irqStatus_r[ecd_pkg::IRQ_TIMEOUT_BIT])
    else $error("Time-out flag missed.");
  a_prescale_div8: assert property (ctrl_r.prescaleSelect == 2'h3 && tick |-> divCnt_r == 3'h7)
    else $error("Divide by eight ticked early.");
  a_irq_gated: assert property (irqOut |-> (ctrl_r.timeoutIntEn && irqStatus_r[0] && irqMask_r[0])
                                || (ctrl_r.captureIntEn && |(irqStatus_r[2:1] & irqMask_r[2:1])))
    else $error("Interrupt raised while disabled.");
  a_rise_capture: assert property (seqRiseCapture |=> lowCapture_r == ~$past(count_r)
                                   && count_r == ecd_pkg::COUNT_ALL_ONES)
    else $error("Rising capture value or reload wrong.");
  a_fall_status: assert property (seqFallCapture |=> edge_r.fallDetect
                                  ##0 highCapture_r == ~$past(count_r, 1))
    else $error("Falling capture status missing.");
  a_wait_hold: assert property (state_r == ecd_pkg::ST_WAIT_EDGE && !riseQual && !fallQual
                                |=> $stable(count_r))
    else $error("Counted before the first edge.");
  a_recovery_keep: assert property (stopRecovery && !regWr |=> !ctrl_r.enable
                                    && ctrl_r.prescaleSelect == $past(ctrl_r.prescaleSelect))
    else $error("Stop-mode recovery disturbed kept bits.");
endmodule

`default_nettype wire

// File: shared/ecd_pkg.sv
// Shared constants and types for the eight-bit counter and demodulator.
package ecd_pkg;
  // Register offsets on the plain register port.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LOW_HOLD = 8'h04;
  localparam logic [7:0] REG_HIGH_HOLD = 8'h05;
  localparam logic [7:0] REG_LOW_CAPTURE = 8'h06;
  localparam logic [7:0] REG_HIGH_CAPTURE = 8'h07;
  localparam logic [7:0] REG_EDGE_CTRL = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h09;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0a;
  // Field positions in the counter control register.
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_SINGLE_BIT = 6;
  localparam int CTRL_TIMEOUT_BIT = 5;
  // Field positions in the edge control register.
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // Interrupt status bit positions.
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_RISE_BIT = 1;
  localparam int IRQ_FALL_BIT = 2;
  // Values after reset and fixed counts.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [7:0] COUNT_ALL_ONES = 8'hff;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  // Edge select codes.
  localparam logic [1:0] EDGE_SEL_RISE = 2'h1;
  localparam logic [1:0] EDGE_SEL_FALL = 2'h2;

  typedef struct packed {
    logic enable;
    logic singlePass;
    logic timeOut;
    logic [1:0] prescaleSelect;
    logic captureIntEn;
    logic timeoutIntEn;
    logic outputPinSelect;
  } ecd_ctrl_t;

  typedef struct packed {
    logic demodMode;
    logic sourceSelect;
    logic [1:0] edgeSelect;
    logic [1:0] spare;
    logic fallDetect;
    logic riseDetect;
  } ecd_edge_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_RUN} ecd_state_t;
endpackage

// File: testbench/ecd_pulse_src.sv
// Pulse source model that drives the two edge input pins of the counter.
`timescale 1ns/10ps
`default_nettype none
module ecd_pulse_src (
  // Clock.
  input wire logic sys_clk,
  // Bench control.
  input wire logic useAlt,
  input wire logic pulseLevel,
  // Edge input pins.
  output logic port3Pin1,
  output logic port2Pin0
);
  // The pin not in use toggles every cycle, so a wrong source pick shows up as stray captures.
  logic noise_r = 1'b0;

  always_ff @(posedge sys_clk) begin
    noise_r <= ~noise_r;
  end

  assign port3Pin1 = useAlt ? noise_r : pulseLevel;
  assign port2Pin0 = useAlt ? pulseLevel : noise_r;
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the eight-bit counter and demodulator.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic stopRecovery = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic portOutData = 1'b0;
  logic useAlt = 1'b0;
  logic pulseLevel = 1'b0;
  logic port3Pin1;
  logic port2Pin0;
  logic port3Pin4;
  logic irqOut;
  logic [7:0] v;
  logic [7:0] capHigh;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc;

  always #2 sys_clk = ~sys_clk;

  ecd_counter uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .stopRecovery(stopRecovery),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .port3Pin1(port3Pin1), .port2Pin0(port2Pin0), .portOutData(portOutData), .port3Pin4(port3Pin4),
    .irqOut(irqOut)
  );

  ecd_pulse_src src (
    .sys_clk(sys_clk), .useAlt(useAlt), .pulseLevel(pulseLevel), .port3Pin1(port3Pin1), .port2Pin0(port2Pin0)
  );

  // ****************************************
  // Access and checking tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobes drop after the sampling edge and one idle edge follows, so calls may come back to back.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
    @(posedge sys_clk);
  endtask

  task automatic irqIs(input logic e);
    @(negedge sys_clk);
    chk("irq", {7'h00, irqOut}, {7'h00, e});
    @(posedge sys_clk);
  endtask

  // Waits for a pin toggle, then counts cycles to the next one.
  task automatic pinPeriod(output int c);
    logic last;
    @(negedge sys_clk);
    last = port3Pin4;
    for (c = 0; c < 100 && port3Pin4 === last; c++) @(negedge sys_clk);
    last = port3Pin4;
    for (c = 0; c < 100 && port3Pin4 === last; c++) @(negedge sys_clk);
    if (c >= 100) begin
      n_mismatch++;
      $display("Error pin toggle expected toggle seen none");
      test_done();
    end
    @(posedge sys_clk);
  endtask

  task automatic endTest(input string name);
    $display("Test %s finished, mismatches so far %0d", name, n_mismatch);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(ecd_pkg::REG_CTRL, v);
    chk("ctrl reset", v, ecd_pkg::CTRL_RESET);
    rd(ecd_pkg::REG_LOW_HOLD, v);
    chk("low hold reset", v, ecd_pkg::HOLD_RESET);
    wr(8'h03, 8'h5a);
    rd(8'h03, v);
    chk("unmapped", v, 8'h00);
    wr(ecd_pkg::REG_LOW_HOLD, 8'ha5);
    wr(ecd_pkg::REG_HIGH_HOLD, 8'h5a);
    rd(ecd_pkg::REG_LOW_HOLD, v);
    chk("low hold", v, 8'ha5);
    rd(ecd_pkg::REG_HIGH_HOLD, v);
    chk("high hold", v, 8'h5a);
    endTest("registers");
    wr(ecd_pkg::REG_LOW_HOLD, 8'h04);
    wr(ecd_pkg::REG_HIGH_HOLD, 8'h04);
    for (int p = 0; p < 4; p++) begin
      wr(ecd_pkg::REG_CTRL, 8'h81 | 8'(p << 3));
      pinPeriod(cyc);
      pinPeriod(cyc);
      chk("pin period", 8'(cyc), 8'(4 << p));
    end
    wr(ecd_pkg::REG_CTRL, 8'h00);
    portOutData <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pin as port", {7'h00, port3Pin4}, 8'h01);
    @(posedge sys_clk);
    endTest("prescale and pin");
    wr(ecd_pkg::REG_LOW_HOLD, 8'h02);
    wr(ecd_pkg::REG_CTRL, 8'hc0);
    repeat (10) @(posedge sys_clk);
    rd(ecd_pkg::REG_CTRL, v);
    chk("single pass end", v, 8'h60);
    irqIs(1'b0);
    wr(ecd_pkg::REG_CTRL, 8'h5f);
    rd(ecd_pkg::REG_CTRL, v);
    chk("zero leaves flag", v, 8'h7f);
    stopRecovery <= 1'b1;
    @(posedge sys_clk);
    stopRecovery <= 1'b0;
    @(posedge sys_clk);
    rd(ecd_pkg::REG_CTRL, v);
    chk("after recovery", v, 8'h3e);
    wr(ecd_pkg::REG_IRQ_MASK, 8'h01);
    irqIs(1'b1);
    wr(ecd_pkg::REG_IRQ_STATUS, 8'h01);
    irqIs(1'b0);
    wr(ecd_pkg::REG_CTRL, 8'h20);
    repeat (10) @(posedge sys_clk);
    rd(ecd_pkg::REG_CTRL, v);
    chk("flag cleared", v, 8'h00);
    endTest("single pass and recovery");
    for (int s = 0; s < 2; s++) begin
      // Pins settle before the source switch, so no stray edge meets the waiting counter.
      useAlt <= s[0];
      pulseLevel <= 1'b0;
      wr(ecd_pkg::REG_LOW_HOLD, 8'hff);
      wr(ecd_pkg::REG_HIGH_HOLD, 8'hff);
      wr(ecd_pkg::REG_EDGE_CTRL, 8'hb0 | 8'(s << 6));
      wr(ecd_pkg::REG_IRQ_MASK, 8'h07);
      wr(ecd_pkg::REG_CTRL, 8'h86);
      repeat (8) @(posedge sys_clk);
      pulseLevel <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(ecd_pkg::REG_IRQ_STATUS, v);
      chk("first edge", v, 8'h00);
      repeat (34) @(posedge sys_clk);
      pulseLevel <= 1'b0;
      repeat (50) @(posedge sys_clk);
      pulseLevel <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd(ecd_pkg::REG_HIGH_CAPTURE, capHigh);
      chk("high capture", {7'h00, capHigh inside {[8'h26:8'h2a]}}, 8'h01);
      rd(ecd_pkg::REG_LOW_CAPTURE, v);
      chk("capture spacing", v - capHigh, 8'h0a);
      rd(ecd_pkg::REG_IRQ_STATUS, v);
      chk("capture status", v, 8'h06);
      irqIs(1'b1);
      rd(ecd_pkg::REG_EDGE_CTRL, v);
      chk("edge bits", v, 8'hb3 | 8'(s << 6));
      repeat (300) @(posedge sys_clk);
      rd(ecd_pkg::REG_IRQ_STATUS, v);
      chk("demod time-out", v, 8'h07);
      rd(ecd_pkg::REG_CTRL, v);
      chk("demod flag", v, 8'ha6);
      wr(ecd_pkg::REG_CTRL, 8'h06);
      wr(ecd_pkg::REG_CTRL, 8'h26);
      wr(ecd_pkg::REG_IRQ_STATUS, 8'h07);
      wr(ecd_pkg::REG_EDGE_CTRL, 8'hb3 | 8'(s << 6));
      irqIs(1'b0);
      rd(ecd_pkg::REG_CTRL, v);
      chk("stopped", v, 8'h06);
      endTest("demodulation");
    end
    // Rising edges only: a falling edge neither starts the count nor captures.
    useAlt <= 1'b0;
    wr(ecd_pkg::REG_EDGE_CTRL, 8'h90);
    wr(ecd_pkg::REG_CTRL, 8'h86);
    pulseLevel <= 1'b0;
    repeat (8) @(posedge sys_clk);
    pulseLevel <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pulseLevel <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(ecd_pkg::REG_IRQ_STATUS, v);
    chk("rise only fall", v, 8'h00);
    pulseLevel <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(ecd_pkg::REG_IRQ_STATUS, v);
    chk("rise only rise", v, 8'h02);
    wr(ecd_pkg::REG_CTRL, 8'h06);
    endTest("rise only");
    test_done();
  end
endmodule
`default_nettype wire
